// ==== core/wdt_pkg.sv ====
// Purpose: Shared constants and types of the windowed watchdog timer
// Assumes: Avalon-MM byte addressing, 32-bit data, register index times four
// Notes:   Option byte layout and overflow exponents live here only
package wdt_pkg;
    localparam int          ADDR_W          = 22;
    localparam int          DATA_W          = 32;
    localparam int          CNT_W           = 17;
    localparam int          SYNC_W          = 3;

    // Register indices and their byte addresses
    localparam logic [19:0] REFRESH_IDX     = 20'hfffab;
    localparam logic [19:0] STATUS_IDX      = 20'hfffac;
    localparam logic [21:0] REFRESH_ADDR    = {REFRESH_IDX, 2'b00};
    localparam logic [21:0] STATUS_ADDR     = {STATUS_IDX, 2'b00};

    // Refresh register values
    localparam logic [7:0]  REFRESH_KEY     = 8'hac;
    localparam logic [7:0]  REFRESH_RV_ON   = 8'h9a;
    localparam logic [7:0]  REFRESH_RV_OFF  = 8'h1a;

    // Option byte fields
    localparam int          OPT_IRQ_BIT     = 7;
    localparam int          OPT_FRAC_HI     = 6;
    localparam int          OPT_FRAC_LO     = 5;
    localparam int          OPT_EN_BIT      = 4;
    localparam int          OPT_OVF_HI      = 3;
    localparam int          OPT_OVF_LO      = 1;
    localparam int          OPT_STBY_BIT    = 0;
    localparam logic [7:0]  OPT_RESET       = 8'h00;

    // Open fraction codes
    localparam logic [1:0]  FRAC_HALF       = 2'b01;
    localparam logic [1:0]  FRAC_QUARTER3   = 2'b10;

    // Overflow time exponents in low-speed clock cycles
    localparam int          OVF_EXP_0       = 6;
    localparam int          OVF_EXP_1       = 7;
    localparam int          OVF_EXP_2       = 8;
    localparam int          OVF_EXP_3       = 9;
    localparam int          OVF_EXP_4       = 11;
    localparam logic [2:0]  OVF_CODE_0      = 3'b000;
    localparam logic [2:0]  OVF_CODE_1      = 3'b001;
    localparam logic [2:0]  OVF_CODE_2      = 3'b010;
    localparam logic [2:0]  OVF_CODE_3      = 3'b011;

    // Status register fields
    localparam int          STAT_CNT_LO     = 0;
    localparam int          STAT_CLOSED_BIT = 17;
    localparam int          STAT_FIRST_BIT  = 18;
    localparam int          STAT_RUN_BIT    = 19;
    localparam int          STAT_FIRED_BIT  = 20;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_FIRED
    } wdt_state_e;
endpackage

// ==== core/wdt_sync.sv ====
// Purpose: Two-stage synchroniser, one chain per bit
// Assumes: Inputs are asynchronous to clk
// Notes:   Only the second stage may be read by other logic
`timescale 1ns/1ps
`default_nettype none
module wdt_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            logic stab_q;
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q <= 1'b0;
                    stab_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    stab_q <= meta_q;
                end
            end
            assign sync_out[i] = stab_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== core/wdt_top.sv ====
// Purpose: Windowed watchdog timer with an Avalon-MM refresh register
// Assumes: Low-speed oscillator and standby levels arrive as pins
// Notes:   Once it fires, the internal reset holds until arst_n
// Behaviour
// - Key write clears counter and restarts
// - Refresh reset value follows enable option
// - Non-key write raises internal reset
// - Single-bit access raises internal reset
// - Refresh reads return reset value only
// - Enable option starts or stops counting
// - Later writes in closed window reset
// - Overflow without refresh raises internal reset
// - First write ignores window, clears counter
// - Clear may lag write by two ticks
// - Standby option selects counting in standby
// - Halt or stop release clears and restarts counter
// - Overflow select picks two-power period
// - Window select picks open fraction
// - Standby option zero forces full window
// - Refresh accepted up to last count
// - Interval interrupt at three quarters plus half
// - Watchdog reset sets cause flag
// - Counter is 17 bits on low-speed clock
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic              avs_bit_access,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic [7:0]        option_byte,
    input  wire logic              low_speed_clk,
    input  wire logic              halt_mode,
    input  wire logic              stop_mode,
    input  wire logic              doze_mode,
    output logic                   wdt_reset,
    output logic                   interval_irq,
    output logic                   watchdog_cause_flag
);
    logic [SYNC_W-1:0] sync_s;
    logic              ls_s;
    logic              hs_s;
    logic              doze_s;
    logic              ls_prev_q;
    logic              hs_prev_q;
    logic              tick_rise;
    logic              tick_fall;
    logic              ack_q;
    logic [DATA_W-1:0] rdata_q;
    logic              acc_wr;
    logic              ref_hit;
    logic              stat_hit;
    logic              ref_wr;
    logic [7:0]        opt_q;
    logic              opt_loaded_q;
    wdt_state_e        state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic [CNT_W-1:0]  cnt_d;
    logic [CNT_W-1:0]  ovf_n;
    logic [CNT_W-1:0]  ovf_last;
    logic [CNT_W-1:0]  closed_lim;
    logic [CNT_W-1:0]  irq_pt;
    logic              closed;
    logic              first_done_q;
    logic              valid_clr;
    logic              bad_wr;
    logic              overflow;
    logic              hold;
    logic              release_clr;
    logic              irq_done_q;
    logic              irq_q;
    logic              fired_q;
    logic              cause_q;
    logic [7:0]        ref_rv;

    // Oscillator and standby levels come from other domains
    wdt_sync #(.W(SYNC_W)) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({doze_mode, halt_mode | stop_mode, low_speed_clk}),
        .sync_out (sync_s)
    );
    assign ls_s   = sync_s[0];
    assign hs_s   = sync_s[1];
    assign doze_s = sync_s[2];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ls_prev_q <= 1'b0;
            hs_prev_q <= 1'b0;
        end else begin
            ls_prev_q <= ls_s;
            hs_prev_q <= hs_s;
        end
    end
    assign tick_rise = ls_s & ~ls_prev_q;
    assign tick_fall = ~ls_s & ls_prev_q;

    // Option byte is a strap, taken at the first edge after release
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            opt_q        <= OPT_RESET;
            opt_loaded_q <= 1'b0;
        end else if (!opt_loaded_q) begin
            opt_q        <= option_byte;
            opt_loaded_q <= 1'b1;
        end
    end

    // Bus slave: one wait state on every access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign acc_wr          = avs_write & ack_q;
    assign avs_readdata    = rdata_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_comb begin
        ref_hit  = 1'b0;
        stat_hit = 1'b0;
        if (avs_address == REFRESH_ADDR) begin
            ref_hit = 1'b1;
        end else if (avs_address == STATUS_ADDR) begin
            stat_hit = 1'b1;
        end
    end

    assign ref_rv = opt_q[OPT_EN_BIT] ? REFRESH_RV_ON : REFRESH_RV_OFF;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else if (avs_read && !ack_q) begin
            rdata_q <= '0;
            if (ref_hit) begin
                rdata_q[7:0] <= ref_rv;
            end else if (stat_hit) begin
                rdata_q[STAT_CNT_LO +: CNT_W] <= cnt_q;
                rdata_q[STAT_CLOSED_BIT]      <= closed;
                rdata_q[STAT_FIRST_BIT]       <= first_done_q;
                rdata_q[STAT_RUN_BIT]         <= (state_q == ST_RUN);
                rdata_q[STAT_FIRED_BIT]       <= fired_q;
            end
        end
    end

    // Lane 0 must be enabled; a write without it does not reach the register
    assign ref_wr = acc_wr & ref_hit & avs_byteenable[0];

    // Overflow period and window bounds
    always_comb begin
        case (opt_q[OPT_OVF_HI:OPT_OVF_LO])
            OVF_CODE_0: ovf_n = CNT_W'(1) << OVF_EXP_0;
            OVF_CODE_1: ovf_n = CNT_W'(1) << OVF_EXP_1;
            OVF_CODE_2: ovf_n = CNT_W'(1) << OVF_EXP_2;
            OVF_CODE_3: ovf_n = CNT_W'(1) << OVF_EXP_3;
            default:    ovf_n = CNT_W'(1) << OVF_EXP_4;
        endcase
    end
    assign ovf_last = ovf_n - CNT_W'(1);
    assign irq_pt   = ovf_n - (ovf_n >> 2);

    always_comb begin
        closed_lim = '0;
        if (opt_q[OPT_STBY_BIT]) begin
            if (opt_q[OPT_FRAC_HI:OPT_FRAC_LO] == FRAC_HALF) begin
                closed_lim = ovf_n >> 1;
            end else if (opt_q[OPT_FRAC_HI:OPT_FRAC_LO] == FRAC_QUARTER3) begin
                closed_lim = ovf_n >> 2;
            end
        end
    end
    assign closed = first_done_q & (cnt_q < closed_lim);

    // Refresh checks
    assign valid_clr = ref_wr & (avs_writedata[7:0] == REFRESH_KEY) & ~avs_bit_access & ~closed
                     & (state_q != ST_FIRED);
    assign bad_wr    = ref_wr & (state_q != ST_FIRED)
                     & ((avs_writedata[7:0] != REFRESH_KEY)
                        | avs_bit_access
                        | closed);

    assign hold        = (hs_s | doze_s) & ~opt_q[OPT_STBY_BIT];
    assign release_clr = hs_prev_q & ~hs_s & ~opt_q[OPT_STBY_BIT];
    assign overflow    = (state_q == ST_RUN) & tick_rise & ~hold & (cnt_q == ovf_last) & ~valid_clr;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            first_done_q <= 1'b0;
        end else if (ref_wr) begin
            first_done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (bad_wr) begin
                        state_q <= ST_FIRED;
                    end else if (opt_loaded_q && opt_q[OPT_EN_BIT]) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (bad_wr || overflow) begin
                        state_q <= ST_FIRED;
                    end
                end
                default: begin
                    state_q <= ST_FIRED;
                end
            endcase
        end
    end

    // Clear lands at once, well inside the two-tick allowance
    always_comb begin
        cnt_d = cnt_q;
        if (valid_clr || release_clr) begin
            cnt_d = '0;
        end else if (state_q == ST_RUN && tick_rise && !hold) begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Interval interrupt on the falling half after the three-quarter count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q      <= 1'b0;
            irq_done_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (valid_clr || release_clr) begin
                irq_done_q <= 1'b0;
            end else if (opt_q[OPT_IRQ_BIT] && state_q == ST_RUN && tick_fall && !irq_done_q
                         && cnt_q == irq_pt) begin
                irq_q      <= 1'b1;
                irq_done_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fired_q <= 1'b0;
            cause_q <= 1'b0;
        end else if (bad_wr || overflow) begin
            fired_q <= 1'b1;
            cause_q <= 1'b1;
        end
    end

    assign wdt_reset           = fired_q;
    assign interval_irq        = irq_q;
    assign watchdog_cause_flag = cause_q;
    property p_key_clears;
        @(posedge clk) disable iff (!arst_n)
        valid_clr |=> (cnt_q == '0) && !fired_q;
    endproperty
    a_key_clears: assert property (p_key_clears) else $error("key write did not clear");
    property p_read_value;
        @(posedge clk) disable iff (!arst_n)
        (avs_read && !ack_q && ref_hit)
            |=> avs_readdata == DATA_W'(opt_q[OPT_EN_BIT] ? REFRESH_RV_ON : REFRESH_RV_OFF);
    endproperty
    a_read_value: assert property (p_read_value) else $error("refresh read value wrong");
    property p_bad_value;
        @(posedge clk) disable iff (!arst_n)
        (ref_wr && avs_writedata[7:0] != REFRESH_KEY && !fired_q) |=> wdt_reset && watchdog_cause_flag;
    endproperty
    a_bad_value: assert property (p_bad_value) else $error("wrong value did not reset");
    property p_bit_access;
        @(posedge clk) disable iff (!arst_n)
        (ref_wr && avs_bit_access) |=> wdt_reset;
    endproperty
    a_bit_access: assert property (p_bit_access) else $error("bit access did not reset");
    property p_disabled_stops;
        @(posedge clk) disable iff (!arst_n)
        (opt_loaded_q && !opt_q[OPT_EN_BIT]) ##1 opt_loaded_q |-> cnt_q == '0;
    endproperty
    a_disabled_stops: assert property (p_disabled_stops) else $error("counter moved while disabled");
    property p_closed_write;
        @(posedge clk) disable iff (!arst_n)
        (ref_wr && first_done_q && cnt_q < closed_lim) |=> wdt_reset;
    endproperty
    a_closed_write: assert property (p_closed_write) else $error("closed window write missed");
    property p_overflow;
        @(posedge clk) disable iff (!arst_n)
        (state_q == ST_RUN && tick_rise && !hold && cnt_q == ovf_last && !ref_wr) |=> wdt_reset;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow did not reset");
    property p_first_free;
        @(posedge clk) disable iff (!arst_n)
        (ref_wr && !first_done_q && avs_writedata[7:0] == REFRESH_KEY && !avs_bit_access && !fired_q)
            |=> !wdt_reset && cnt_q == '0;
    endproperty
    a_first_free: assert property (p_first_free) else $error("first write was refused");
    property p_standby_hold;
        @(posedge clk) disable iff (!arst_n)
        (hold && !ref_wr && !release_clr) |=> $stable(cnt_q);
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("counted during standby");
    property p_full_window;
        @(posedge clk) disable iff (!arst_n)
        (ref_wr && first_done_q && !opt_q[OPT_STBY_BIT] && avs_writedata[7:0] == REFRESH_KEY && !avs_bit_access)
            |=> !$rose(wdt_reset);
    endproperty
    a_full_window: assert property (p_full_window) else $error("key write refused without standby option");
    property p_irq_point;
        @(posedge clk) disable iff (!arst_n)
        $rose(interval_irq) |-> $past(cnt_q) == irq_pt && opt_q[OPT_IRQ_BIT] && $past(tick_fall);
    endproperty
    a_irq_point: assert property (p_irq_point) else $error("interval interrupt at wrong count");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the windowed watchdog timer
// Assumes: One system clock; each low-speed tick is 4 clk high then 4 clk low
// Notes:   Every scenario restarts the block with its own option byte
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
    import wdt_pkg::*;
    logic              clk;
    logic              arst_n;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0]        avs_byteenable;
    logic              avs_bit_access;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic [7:0]        option_byte;
    logic              low_speed_clk;
    logic              halt_mode;
    logic              stop_mode;
    logic              doze_mode;
    logic              wdt_reset;
    logic              interval_irq;
    logic              watchdog_cause_flag;
    logic [DATA_W-1:0] rdata;
    int                error_cnt;
    int                checked;
    int                irq_cnt;

    wdt_top DUT (
        .clk                 (clk),
        .arst_n              (arst_n),
        .avs_address         (avs_address),
        .avs_read            (avs_read),
        .avs_write           (avs_write),
        .avs_writedata       (avs_writedata),
        .avs_byteenable      (avs_byteenable),
        .avs_bit_access      (avs_bit_access),
        .avs_readdata        (avs_readdata),
        .avs_waitrequest     (avs_waitrequest),
        .option_byte         (option_byte),
        .low_speed_clk       (low_speed_clk),
        .halt_mode           (halt_mode),
        .stop_mode           (stop_mode),
        .doze_mode           (doze_mode),
        .wdt_reset           (wdt_reset),
        .interval_irq        (interval_irq),
        .watchdog_cause_flag (watchdog_cause_flag)
    );

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (interval_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Option strap is only taken at the first edge after release
    task automatic restart(input logic [7:0] opt);
        arst_n        <= 1'b0;
        option_byte   <= opt;
        low_speed_clk <= 1'b0;
        halt_mode     <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] v,
                       input logic bit_acc, output logic [DATA_W-1:0] rd);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, v};
        avs_bit_access <= bit_acc;
        avs_write      <= wr;
        avs_read       <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write      <= 1'b0;
        avs_read       <= 1'b0;
        avs_bit_access <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] v, input logic bit_acc);
        logic [DATA_W-1:0] dummy;
        bus(1'b1, REFRESH_ADDR, v, bit_acc, dummy);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        bus(1'b0, a, 8'h00, 1'b0, rdata);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            low_speed_clk <= 1'b1;
            repeat (4) @(posedge clk);
            low_speed_clk <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    task automatic sc_regs();
        restart(8'h79);
        rd(REFRESH_ADDR);
        `CHK(rdata[7:0], REFRESH_RV_ON)
        avs_byteenable <= 4'h2;
        wr(8'h55, 1'b0);
        avs_byteenable <= 4'h1;
        `CHK(wdt_reset, 1'b0)
        wr(REFRESH_KEY, 1'b0);
        rd(REFRESH_ADDR);
        `CHK(rdata[7:0], REFRESH_RV_ON)
        rd(22'h000000);
        `CHK(rdata, 32'h00000000)
        tick(5);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00005)
        wr(REFRESH_KEY, 1'b0);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00000)
        `CHK(wdt_reset, 1'b0)
        halt_mode <= 1'b1;
        tick(3);
        halt_mode <= 1'b0;
        repeat (4) @(posedge clk);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00003)
        `CHK(rdata[STAT_RUN_BIT], 1'b1)
        `CHK(rdata[STAT_FIRST_BIT], 1'b1)
    endtask

    task automatic sc_bad(input logic [7:0] v, input logic bit_acc);
        restart(8'h79);
        wr(v, bit_acc);
        `CHK(wdt_reset, 1'b1)
        `CHK(watchdog_cause_flag, 1'b1)
        tick(2);
        `CHK(wdt_reset, 1'b1)
    endtask

    task automatic sc_disabled();
        restart(8'h69);
        rd(REFRESH_ADDR);
        `CHK(rdata[7:0], REFRESH_RV_OFF)
        tick(70);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00000)
        `CHK(wdt_reset, 1'b0)
    endtask

    // Every legal overflow code, checked one tick short and at overflow
    task automatic sc_overflow();
        int exps[5];
        exps = '{OVF_EXP_0, OVF_EXP_1, OVF_EXP_2, OVF_EXP_3, OVF_EXP_4};
        for (int c = 0; c < 5; c++) begin
            restart(8'h71 | 8'(c << 1));
            tick((1 << exps[c]) - 1);
            `CHK(wdt_reset, 1'b0)
            tick(1);
            `CHK(wdt_reset, 1'b1)
            `CHK(watchdog_cause_flag, 1'b1)
        end
    endtask

    // Overflow 64 ticks; closed is the closed-window length in ticks
    task automatic sc_window(input logic [7:0] opt, input int closed);
        restart(opt);
        wr(REFRESH_KEY, 1'b0);
        if (closed > 0) begin
            tick(closed - 1);
            wr(REFRESH_KEY, 1'b0);
            `CHK(wdt_reset, 1'b1)
            restart(opt);
            wr(REFRESH_KEY, 1'b0);
        end
        tick(closed);
        wr(REFRESH_KEY, 1'b0);
        `CHK(wdt_reset, 1'b0)
        tick(63);
        wr(REFRESH_KEY, 1'b0);
        tick(1);
        `CHK(wdt_reset, 1'b0)
    endtask

    task automatic sc_standby();
        restart(8'h78);
        tick(5);
        halt_mode <= 1'b1;
        repeat (4) @(posedge clk);
        tick(5);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00005)
        halt_mode <= 1'b0;
        repeat (6) @(posedge clk);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00000)
        tick(2);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00002)
        doze_mode <= 1'b1;
        repeat (4) @(posedge clk);
        tick(3);
        doze_mode <= 1'b0;
        stop_mode <= 1'b1;
        repeat (4) @(posedge clk);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00002)
        stop_mode <= 1'b0;
        repeat (6) @(posedge clk);
        rd(STATUS_ADDR);
        `CHK(rdata[CNT_W-1:0], 17'h00000)
    endtask

    task automatic sc_irq();
        int base;
        restart(8'hf1);
        base = irq_cnt;
        tick(47);
        `CHK(irq_cnt, base)
        tick(2);
        `CHK(irq_cnt, base + 1)
        `CHK(wdt_reset, 1'b0)
    endtask

    initial begin
        clk            = 1'b0;
        arst_n         = 1'b0;
        avs_address    = '0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = '0;
        avs_byteenable = 4'h1;
        avs_bit_access = 1'b0;
        option_byte    = 8'h79;
        low_speed_clk  = 1'b0;
        halt_mode      = 1'b0;
        stop_mode      = 1'b0;
        doze_mode      = 1'b0;
        error_cnt      = 0;
        checked        = 0;
        irq_cnt        = 0;
        @(posedge clk);
        sc_regs();
        sc_bad(8'h55, 1'b0);
        sc_bad(REFRESH_KEY, 1'b1);
        sc_disabled();
        sc_overflow();
        sc_window(8'h31, 32);
        sc_window(8'h51, 16);
        sc_window(8'h71, 0);
        sc_window(8'h30, 0);
        sc_standby();
        sc_irq();
        conclude();
    end

    // Longest expected run is near 30k cycles
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        $display("Error at %0t: run did not finish in time", $time);
        conclude();
    end
endmodule
`undef CHK
`default_nettype wire
